// ### rtl/dsr_pkg.sv
// constants and carrier types for the deserializer serial configuration bank
// assumes a two-wire bus sampled as synchronous inputs of i_mclk
package dsr_pkg;
   localparam logic [7:0] DSR_OFS_CONFIG   = 8'h00;
   localparam logic [7:0] DSR_OFS_IDENTITY = 8'h01;
   localparam logic [7:0] DSR_OFS_FEATURES = 8'h02;
   localparam logic [7:0] DSR_RST_CONFIG   = 8'h00;
   localparam logic [7:0] DSR_RST_IDENTITY = 8'h70;
   localparam logic [7:0] DSR_RST_FEATURES = 8'h00;
   localparam logic [6:0] DSR_ADDR_R047    = 7'h71;
   localparam logic [6:0] DSR_ADDR_R2K7    = 7'h72;
   localparam logic [6:0] DSR_ADDR_R8K2    = 7'h73;
   localparam logic [6:0] DSR_ADDR_OPEN    = 7'h76;
   localparam logic [3:0] DSR_BIT_LAST     = 4'h7;
   localparam logic [3:0] DSR_BIT_ACK      = 4'h8;

   typedef enum logic [1:0] {
      DSR_STRAP_R047,
      DSR_STRAP_R2K7,
      DSR_STRAP_R8K2,
      DSR_STRAP_OPEN
   } dsr_strap_t;

   typedef enum logic [1:0] {
      DSR_FILT_OFF = 2'h0,
      DSR_FILT_ON  = 2'h1,
      DSR_FILT_RS2 = 2'h2,
      DSR_FILT_RS3 = 2'h3
   } dsr_filt_t;

   typedef struct packed {
      logic       low_freq_spread_mode;
      logic       lane_bit_map_select;
      logic [1:0] rsvd;
      dsr_filt_t  filter_mode;
      logic       sleep_req;
      logic       reg_config_en;
   } dsr_config_t;

   typedef struct packed {
      logic       addr_source_select;
      logic [6:0] slave_address_value;
   } dsr_identity_t;

   typedef struct packed {
      logic       parallel_output_enable;
      logic       output_sleep_state_choice;
      logic [1:0] rsvd;
      logic       output_swing_select;
      logic [2:0] internal_osc_freq_choice;
   } dsr_features_t;

   // effective settings handed to the datapath
   typedef struct packed {
      logic       low_freq_spread_mode;
      logic       lane_bit_map_select;
      logic       filter_en;
      logic       sleep;
      logic       parallel_output_enable;
      logic       output_sleep_state_choice;
      logic       output_swing_select;
      logic [2:0] internal_osc_freq_choice;
   } dsr_settings_t;

   // pin-strap fallbacks used while register configuration is off
   typedef struct packed {
      logic low_freq_spread_mode;
      logic lane_bit_map_select;
      logic filter_en;
      logic parallel_output_enable;
      logic output_sleep_state_choice;
      logic output_swing_select;
   } dsr_pins_t;
endpackage : dsr_pkg

// ### rtl/dsr_serial_config_regs.sv
// two-wire serial slave and three-register configuration bank
// assumes scl/sda sampled on i_mclk, several clocks per bus bit
`timescale 1ns/1ps
module dsr_serial_config_regs (
   input  wire logic                   i_mclk,
   input  wire logic                   i_rstn,
   input  wire logic                   i_scl,
   input  wire logic                   i_sda,
   input  wire dsr_pkg::dsr_strap_t    i_bus_addr_strap,
   input  wire dsr_pkg::dsr_pins_t     i_pins,
   output logic                        o_sda_out,
   output logic                        o_sda_oe,
   output dsr_pkg::dsr_settings_t      o_settings,
   output dsr_pkg::dsr_config_t        o_config,
   output dsr_pkg::dsr_identity_t      o_identity,
   output dsr_pkg::dsr_features_t      o_features
);
   typedef enum logic [2:0] {
      DSR_IDLE, DSR_ADDR, DSR_ADDR_ACK, DSR_REG, DSR_WDATA, DSR_DATA_ACK,
      DSR_RDATA, DSR_RD_ACK
   } dsr_state_t;

   function automatic logic [6:0] strap_addr(input dsr_pkg::dsr_strap_t s);
      case (s)
         dsr_pkg::DSR_STRAP_R047: strap_addr = dsr_pkg::DSR_ADDR_R047;
         dsr_pkg::DSR_STRAP_R2K7: strap_addr = dsr_pkg::DSR_ADDR_R2K7;
         dsr_pkg::DSR_STRAP_R8K2: strap_addr = dsr_pkg::DSR_ADDR_R8K2;
         default:                 strap_addr = dsr_pkg::DSR_ADDR_OPEN;
      endcase
   endfunction : strap_addr

   function automatic logic [7:0] reg_read(input logic [7:0] a,
                                           input dsr_pkg::dsr_config_t c,
                                           input dsr_pkg::dsr_identity_t d,
                                           input dsr_pkg::dsr_features_t f);
      case (a)
         dsr_pkg::DSR_OFS_CONFIG:   reg_read = c;
         dsr_pkg::DSR_OFS_IDENTITY: reg_read = d;
         dsr_pkg::DSR_OFS_FEATURES: reg_read = f;
         default:                   reg_read = 8'h00;
      endcase
   endfunction : reg_read

   dsr_state_t             state_ff;
   logic                   scl_d_ff;
   logic                   sda_d_ff;
   logic [3:0]             bit_cnt_ff;
   logic [7:0]             shift_ff;
   logic [7:0]             ptr_ff;
   logic                   rd_ff;
   logic                   sda_oe_ff;
   dsr_pkg::dsr_config_t   config_ff;
   dsr_pkg::dsr_identity_t identity_ff;
   dsr_pkg::dsr_features_t features_ff;
   dsr_pkg::dsr_settings_t settings_ff;
   dsr_pkg::dsr_settings_t nxt_settings;
   logic [6:0]             my_addr;
   logic                   scl_rise;
   logic                   scl_fall;
   logic                   start_seen;
   logic                   stop_seen;
   logic                   byte_done;
   logic [7:0]             rx_byte;
   logic [7:0]             rd_val;
   logic                   tx_load;
   logic                   tx_next;

   assign scl_rise   = i_scl & ~scl_d_ff;
   assign scl_fall   = ~i_scl & scl_d_ff;
   assign start_seen = i_scl & scl_d_ff & sda_d_ff & ~i_sda;
   assign stop_seen  = i_scl & scl_d_ff & ~sda_d_ff & i_sda;
   assign byte_done  = scl_rise && (bit_cnt_ff == dsr_pkg::DSR_BIT_LAST);
   assign rx_byte    = {shift_ff[6:0], i_sda};
   // register address used only when the strap is overridden
   assign my_addr = identity_ff.addr_source_select ? identity_ff.slave_address_value
                                                   : strap_addr(i_bus_addr_strap);
   assign rd_val  = reg_read(ptr_ff, config_ff, identity_ff, features_ff);
   // fall that opens the first bit of a read byte, then the seven after it
   assign tx_load = scl_fall && (bit_cnt_ff == dsr_pkg::DSR_BIT_ACK) &&
                    ((state_ff == DSR_ADDR_ACK && rd_ff) || state_ff == DSR_RDATA);
   assign tx_next = scl_fall && (state_ff == DSR_RDATA) && (bit_cnt_ff < dsr_pkg::DSR_BIT_LAST);

   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= i_scl;
         sda_d_ff <= i_sda;
      end
   end

   // bit counter and shift register; bits in on scl rise, read bytes out on scl fall
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         bit_cnt_ff <= 4'h0;
         shift_ff   <= 8'h00;
      end else if (start_seen) begin
         // the start's own scl fall wraps this to the first bit slot
         bit_cnt_ff <= dsr_pkg::DSR_BIT_ACK;
         shift_ff   <= 8'h00;
      end else if (scl_rise) begin
         // sending bytes must not be overwritten by the wire's own level
         if (state_ff != DSR_RDATA)
            shift_ff <= rx_byte;
      end else if (scl_fall) begin
         if (bit_cnt_ff == dsr_pkg::DSR_BIT_ACK)
            bit_cnt_ff <= 4'h0;
         else
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
         if (tx_load)
            shift_ff <= rd_val;
         else if (tx_next)
            shift_ff <= {shift_ff[6:0], 1'b0};
      end
   end

   // protocol sequencer
   always_ff @(posedge i_mclk) begin
      if (!i_rstn || stop_seen) begin
         state_ff <= DSR_IDLE;
         rd_ff    <= 1'b0;
      end else if (start_seen) begin
         state_ff <= DSR_ADDR;
      end else begin
         case (state_ff)
            DSR_ADDR: if (byte_done) begin
               // foreign address: stay off the bus until next start
               if (rx_byte[7:1] == my_addr) begin
                  rd_ff    <= rx_byte[0];
                  state_ff <= DSR_ADDR_ACK;
               end else begin
                  state_ff <= DSR_IDLE;
               end
            end
            DSR_ADDR_ACK: if (scl_fall && bit_cnt_ff == dsr_pkg::DSR_BIT_ACK)
               state_ff <= rd_ff ? DSR_RDATA : DSR_REG;
            DSR_REG:   if (byte_done) state_ff <= DSR_DATA_ACK;
            DSR_WDATA: if (byte_done) state_ff <= DSR_DATA_ACK;
            DSR_DATA_ACK: if (scl_fall && bit_cnt_ff == dsr_pkg::DSR_BIT_ACK)
               state_ff <= DSR_WDATA;
            DSR_RDATA: if (scl_fall && bit_cnt_ff == dsr_pkg::DSR_BIT_LAST)
               state_ff <= DSR_RD_ACK;
            DSR_RD_ACK: if (scl_rise)
               state_ff <= i_sda ? DSR_IDLE : DSR_RDATA;
            default: state_ff <= DSR_IDLE;
         endcase
      end
   end

   // register pointer: set by first written byte, advances per data byte
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         ptr_ff <= 8'h00;
      end else if (state_ff == DSR_REG && byte_done) begin
         ptr_ff <= rx_byte;
      end else if ((state_ff == DSR_WDATA && byte_done) ||
                   (state_ff == DSR_RD_ACK && scl_rise)) begin
         ptr_ff <= ptr_ff + 8'h01;
      end
   end

   // register bank; values survive sleep, only reset clears them
   always_ff @(posedge i_mclk) begin
      if (!i_rstn) begin
         config_ff   <= dsr_pkg::DSR_RST_CONFIG;
         identity_ff <= dsr_pkg::DSR_RST_IDENTITY;
         features_ff <= dsr_pkg::DSR_RST_FEATURES;
      end else if (state_ff == DSR_WDATA && byte_done) begin
         // reserved bits and codes stored as written
         case (ptr_ff)
            dsr_pkg::DSR_OFS_CONFIG:   config_ff   <= rx_byte;
            dsr_pkg::DSR_OFS_IDENTITY: identity_ff <= rx_byte;
            dsr_pkg::DSR_OFS_FEATURES: features_ff <= rx_byte;
            default: ;
         endcase
      end
   end

   // data line drive: ack slots low, read data zeros low
   always_ff @(posedge i_mclk) begin
      if (!i_rstn || stop_seen || start_seen) begin
         sda_oe_ff <= 1'b0;
      end else if (scl_fall) begin
         if (bit_cnt_ff == dsr_pkg::DSR_BIT_LAST)
            sda_oe_ff <= (state_ff == DSR_ADDR_ACK) || (state_ff == DSR_DATA_ACK);
         else if (tx_load)
            sda_oe_ff <= ~rd_val[7];
         else if (tx_next)
            sda_oe_ff <= ~shift_ff[6];
         else
            sda_oe_ff <= 1'b0;
      end
   end

   always_comb begin
      nxt_settings.sleep                    = config_ff.sleep_req;
      nxt_settings.internal_osc_freq_choice = features_ff.internal_osc_freq_choice;
      if (config_ff.reg_config_en) begin
         nxt_settings.low_freq_spread_mode      = config_ff.low_freq_spread_mode;
         nxt_settings.lane_bit_map_select       = config_ff.lane_bit_map_select;
         nxt_settings.filter_en = (config_ff.filter_mode == dsr_pkg::DSR_FILT_ON);
         nxt_settings.parallel_output_enable    = features_ff.parallel_output_enable;
         nxt_settings.output_sleep_state_choice = features_ff.output_sleep_state_choice;
         nxt_settings.output_swing_select       = features_ff.output_swing_select;
      end else begin
         nxt_settings.low_freq_spread_mode      = i_pins.low_freq_spread_mode;
         nxt_settings.lane_bit_map_select       = i_pins.lane_bit_map_select;
         nxt_settings.filter_en                 = i_pins.filter_en;
         nxt_settings.parallel_output_enable    = i_pins.parallel_output_enable;
         nxt_settings.output_sleep_state_choice = i_pins.output_sleep_state_choice;
         nxt_settings.output_swing_select       = i_pins.output_swing_select;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rstn)
         settings_ff <= '0;
      else
         settings_ff <= nxt_settings;
   end

   assign o_sda_out  = 1'b0;
   assign o_sda_oe   = sda_oe_ff;
   assign o_settings = settings_ff;
   assign o_config   = config_ff;
   assign o_identity = identity_ff;
   assign o_features = features_ff;
endmodule : dsr_serial_config_regs

// ### sim/dsr_props.sv
// concurrent checks on the configuration bank's ports
// assumes a bind from the bench onto the design's top module
`timescale 1ns/1ps
module dsr_props (
   input wire logic                   i_mclk,
   input wire logic                   i_rstn,
   input wire logic                   i_scl,
   input wire logic                   i_sda,
   input wire dsr_pkg::dsr_strap_t    i_bus_addr_strap,
   input wire dsr_pkg::dsr_pins_t     i_pins,
   input wire logic                   o_sda_out,
   input wire logic                   o_sda_oe,
   input wire dsr_pkg::dsr_settings_t o_settings,
   input wire dsr_pkg::dsr_config_t   o_config,
   input wire dsr_pkg::dsr_identity_t o_identity,
   input wire dsr_pkg::dsr_features_t o_features
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   // reset is the cause here, so it cannot also disable the check
   reset_values_a: assert property (disable iff (1'b0) !i_rstn |=> o_config == 8'h00 &&
      o_identity == 8'h70 && o_features == 8'h00) else $error("reset contents wrong");
   sda_low_only_a: assert property (o_sda_out == 1'b0) else $error("data drive not low");
   ack_scl_low_a: assert property ($rose(o_sda_oe) |-> !i_scl) else $error("drive on high clock");
   drive_steady_a: assert property (i_scl && $past(i_scl) && $past(i_scl, 2) && $past(i_scl, 3)
      |-> $stable(o_sda_oe)) else $error("data changed with clock high");
   reg_select_a: assert property ($past(i_rstn) && $past(o_config.reg_config_en) |->
      o_settings.lane_bit_map_select == $past(o_config.lane_bit_map_select) &&
      o_settings.low_freq_spread_mode == $past(o_config.low_freq_spread_mode) &&
      o_settings.parallel_output_enable == $past(o_features.parallel_output_enable) &&
      o_settings.output_swing_select == $past(o_features.output_swing_select))
      else $error("register settings not used");
   pin_select_a: assert property ($past(i_rstn) && !$past(o_config.reg_config_en) |->
      o_settings.lane_bit_map_select == $past(i_pins.lane_bit_map_select) &&
      o_settings.output_swing_select == $past(i_pins.output_swing_select))
      else $error("pin settings not used");
   filter_code_a: assert property ($past(i_rstn) && $past(o_config.reg_config_en) |->
      o_settings.filter_en == ($past(o_config.filter_mode) == dsr_pkg::DSR_FILT_ON))
      else $error("filter code wrong");
   sleep_osc_a: assert property ($past(i_rstn) |-> o_settings.sleep == $past(o_config.sleep_req) &&
      o_settings.internal_osc_freq_choice == $past(o_features.internal_osc_freq_choice))
      else $error("sleep or oscillator wrong");
   cover property ($rose(o_sda_oe));
   cover property (o_config.reg_config_en && o_settings.sleep);
   cover property (o_identity.addr_source_select);
endmodule : dsr_props

// ### sim/dsr_host_model.sv
// serial bus master model: clock, open-drain data, read byte report
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module dsr_host_model (
   input  wire logic  i_mclk,
   input  wire logic  i_sda,
   output logic       o_scl,
   output logic       o_sda_oe,
   output logic       o_rd_valid,
   output logic [7:0] o_rd_data
);
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
      o_rd_valid = 1'b0;
      o_rd_data = 8'h00;
   end
   task automatic half;
      repeat (5) @(posedge i_mclk);
      #1;
   endtask : half
   // data moves only while the clock is low
   task automatic bit_io(input logic b, output logic s);
      o_sda_oe = ~b;
      half;
      o_scl = 1'b1;
      half;
      s = i_sda;
      o_scl = 1'b0;
   endtask : bit_io
   task automatic start;
      o_sda_oe = 1'b0;
      half;
      o_scl = 1'b1;
      half;
      o_sda_oe = 1'b1;
      half;
      o_scl = 1'b0;
   endtask : start
   task automatic stop;
      o_sda_oe = 1'b1;
      half;
      o_scl = 1'b1;
      half;
      o_sda_oe = 1'b0;
      half;
   endtask : stop
   // msb first, then the acknowledge slot driven as ab
   task automatic byte_io(input logic [7:0] d, input logic ab, output logic [7:0] q,
                          output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ab, s);
      ack = ~s;
   endtask : byte_io
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                     output logic ack);
      logic [7:0] q;
      logic k1, k2, k3;
      start;
      byte_io({a, 1'b0}, 1'b1, q, k1);
      byte_io(p, 1'b1, q, k2);
      byte_io(d, 1'b1, q, k3);
      stop;
      ack = k1 & k2 & k3;
   endtask : wr
   // pointer write, then read one byte and end it with a refusal
   task automatic rd(input logic [6:0] a, input logic [7:0] p);
      logic [7:0] q;
      logic k;
      start;
      byte_io({a, 1'b0}, 1'b1, q, k);
      byte_io(p, 1'b1, q, k);
      stop;
      start;
      byte_io({a, 1'b1}, 1'b1, q, k);
      byte_io(8'hff, 1'b1, q, k);
      stop;
      o_rd_data = q;
      o_rd_valid = 1'b1;
      @(posedge i_mclk);
      #1;
      o_rd_valid = 1'b0;
   endtask : rd
endmodule : dsr_host_model

// ### sim/tb_top.sv
// self-checking bench for the serial configuration bank
// assumes the host model is the only master on the data wire
`timescale 1ns/1ps
module tb_top;
   logic                   i_mclk, i_rstn, scl, sda, m_oe, d_oe, sda_out, rd_valid, k;
   logic [7:0]             rd_data, d;
   dsr_pkg::dsr_strap_t    strap;
   dsr_pkg::dsr_pins_t     pins;
   dsr_pkg::dsr_settings_t set;
   dsr_pkg::dsr_config_t   cfg;
   dsr_pkg::dsr_identity_t idn;
   dsr_pkg::dsr_features_t fea;
   logic [7:0]             expq[$];
   logic [6:0]             adr[4] = '{7'h71, 7'h72, 7'h73, 7'h76};
   int                     n_errors, checks_done, seed = 32'h0488;
   assign sda = !(m_oe || d_oe);
   dsr_serial_config_regs i_dsr_serial_config_regs (.i_mclk(i_mclk), .i_rstn(i_rstn),
      .i_scl(scl), .i_sda(sda), .i_bus_addr_strap(strap), .i_pins(pins), .o_sda_out(sda_out),
      .o_sda_oe(d_oe), .o_settings(set), .o_config(cfg), .o_identity(idn), .o_features(fea));
   dsr_host_model i_dsr_host_model (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl),
      .o_sda_oe(m_oe), .o_rd_valid(rd_valid), .o_rd_data(rd_data));
   initial i_mclk = 1'b0;
   always #20 i_mclk = ~i_mclk;
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   task automatic rd_exp(input logic [6:0] a, input logic [7:0] p, input logic [7:0] e);
      expq.push_back(e);
      i_dsr_host_model.rd(a, p);
   endtask : rd_exp
   task automatic wr_ack(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v,
                         input logic e);
      i_dsr_host_model.wr(a, p, v, k);
      chk("ack", {15'h0000, k}, {15'h0000, e});
   endtask : wr_ack
   always @(posedge i_mclk) if (rd_valid === 1'b1) chk("read", rd_data, expq.pop_front());
   initial begin
      repeat (80000) @(posedge i_mclk);
      n_errors++;
      end_sim;
   end
   initial begin
      i_rstn = 1'b0;
      strap = dsr_pkg::DSR_STRAP_R047;
      pins = dsr_pkg::dsr_pins_t'($random(seed));
      repeat (10) @(posedge i_mclk);
      #1;
      i_rstn = 1'b1;
      chk("rst", {cfg, idn}, 16'h0070);
      chk("rst", fea, 16'h0000);
      for (int s = 0; s < 4; s++) begin
         strap = dsr_pkg::dsr_strap_t'(s);
         d = ($random(seed) & 8'hcb) | 8'h02;
         wr_ack(adr[s], dsr_pkg::DSR_OFS_FEATURES, d, 1'b1);
         rd_exp(adr[s], dsr_pkg::DSR_OFS_FEATURES, d);
      end
      $display("test strap done");
      wr_ack(7'h74, dsr_pkg::DSR_OFS_FEATURES, 8'h00, 1'b0);
      rd_exp(7'h74, dsr_pkg::DSR_OFS_FEATURES, 8'hff);
      rd_exp(adr[3], dsr_pkg::DSR_OFS_FEATURES, d);
      $display("test foreign done");
      wr_ack(adr[3], dsr_pkg::DSR_OFS_IDENTITY, 8'hf2, 1'b1);
      rd_exp(7'h72, dsr_pkg::DSR_OFS_IDENTITY, 8'hf2);
      rd_exp(adr[3], dsr_pkg::DSR_OFS_IDENTITY, 8'hff);
      $display("test identity done");
      wr_ack(7'h72, dsr_pkg::DSR_OFS_CONFIG, 8'h47, 1'b1);
      chk("set", set, {4'hf & 4'h7, d[7], d[6], d[3], d[2:0]});
      rd_exp(7'h72, dsr_pkg::DSR_OFS_FEATURES, d);
      wr_ack(7'h72, dsr_pkg::DSR_OFS_CONFIG, 8'h81, 1'b1);
      chk("set", set, {4'h8, d[7], d[6], d[3], d[2:0]});
      wr_ack(7'h72, dsr_pkg::DSR_OFS_CONFIG, 8'h00, 1'b1);
      chk("set", set, {pins[5:3], 1'b0, pins[2:0], d[2:0]});
      $display("test config done");
      i_rstn = 1'b0;
      repeat (2) @(posedge i_mclk);
      #1;
      i_rstn = 1'b1;
      chk("rst", {cfg, idn}, 16'h0070);
      rd_exp(adr[3], dsr_pkg::DSR_OFS_FEATURES, 8'h00);
      $display("test reset again done");
      end_sim;
   end
endmodule : tb_top
bind dsr_serial_config_regs dsr_props i_dsr_props (.i_mclk(i_mclk), .i_rstn(i_rstn),
   .i_scl(i_scl), .i_sda(i_sda), .i_bus_addr_strap(i_bus_addr_strap), .i_pins(i_pins),
   .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_settings(o_settings), .o_config(o_config),
   .o_identity(o_identity), .o_features(o_features));
